// [src/light_sensor_command_readout.sv]
// command decoding, mode control and result register of the light sensor
// assumes sense_clk is the converter's pulse output and keeps running
// Overview of operation
// - after reset the device sits in shutdown with no conversion running
// - the serial interface keeps answering while in shutdown
// - any command with top bit set selects shutdown; other bits do nothing
// - last written command byte is stored and returned on a byte read in shutdown; active modes return the result
// - 0x0c enters continuous mode; result refreshed every integration period
// - 0x04 enters single mode; host start and stop set the length
// - in single mode 0x08 clears the result and starts integrating
// - in single mode 0x30 ends a running integration and sets the valid flag; with none running it does nothing
// - start and stop commands are ignored in continuous mode
// - continuous mode reports invalid until its first conversion completes
// - a valid result shows flag one and the 15-bit count
// - continuous result takes a new count only when a conversion completes
// - single mode reports invalid until a stop command ends a started integration
// - single result is cleared by a start and takes a new count only at a stop ending that integration
// - result is 16 bits: valid flag at 15, count in 14..0
`timescale 1ns/1ps
module light_sensor_command_readout
  import light_sensor_pkg::*;
#(
  parameter int INT_PERIOD_CYCLES = light_sensor_pkg::INT_CYCLES
)
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // converter pulse clock
  input wire logic sense_clk,
  // serial bus pins
  input wire light_sensor_pkg::i2c_in_t pins_in,
  output light_sensor_pkg::i2c_out_t pins_out,
  // status
  output light_sensor_pkg::mode_t mode,
  output logic [7:0] command,
  output light_sensor_pkg::result_t result,
  output logic integrating,
  output logic bus_busy
);
  import light_sensor_pkg::*;

  localparam int TIMER_W = $clog2(INT_PERIOD_CYCLES + 1);
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(INT_PERIOD_CYCLES - 1);

  function automatic logic [PULSE_W-1:0] gray_to_bin(input logic [PULSE_W-1:0] g);
    logic [PULSE_W-1:0] b;
    b = g;
    for (int i = PULSE_W - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // the count saturates when light overruns 15 bits; beyond 16 bits the pulse difference wraps
  function automatic result_t make_result(input logic [PULSE_W-1:0] now,
                                          input logic [PULSE_W-1:0] base);
    logic [PULSE_W-1:0] diff;
    result_t r;
    diff = now - base;
    r.valid = 1'b1;
    r.count = diff[PULSE_W-1] ? COUNT_MAX : diff[COUNT_W-1:0];
    return r;
  endfunction

  // gray word of a binary pulse count
  function automatic logic [PULSE_W-1:0] bin_to_gray(input logic [PULSE_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // a written byte that matches one command code
  function automatic logic cmd_is(input logic strobe, input logic [7:0] data,
                                  input logic [7:0] code);
    return strobe && (data == code);
  endfunction

  // sense domain: reset crossing and free-running gray pulse counter
  logic [1:0] sense_rst_q;
  logic [PULSE_W-1:0] pulse_bin_q;
  logic [PULSE_W-1:0] pulse_gray_q;
  logic [PULSE_W-1:0] pulse_next;

  assign pulse_next = pulse_bin_q + PULSE_W'(1);

  always_ff @(posedge sense_clk)
  begin
    sense_rst_q <= {sense_rst_q[0], rst_n};
  end

  always_ff @(posedge sense_clk)
  begin
    if (!sense_rst_q[1])
    begin
      pulse_bin_q <= '0;
      pulse_gray_q <= '0;
    end
    else
    begin
      pulse_bin_q <= pulse_next;
      pulse_gray_q <= bin_to_gray(pulse_next);
    end
  end

  // core domain: gray pointer crosses through two flip-flops
  logic [PULSE_W-1:0] gray_meta_q;
  logic [PULSE_W-1:0] gray_sync_q;
  logic [PULSE_W-1:0] pulse_now;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      gray_meta_q <= '0;
      gray_sync_q <= '0;
    end
    else
    begin
      gray_meta_q <= pulse_gray_q;
      gray_sync_q <= gray_meta_q;
    end
  end

  assign pulse_now = gray_to_bin(gray_sync_q);

  // serial bus slave
  logic wr_valid;
  logic [7:0] wr_data;
  logic [15:0] tx_word;

  serial_byte_slave u_slave (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pins_in(pins_in),
    .pins_out(pins_out),
    .tx_word(tx_word),
    .wr_valid(wr_valid),
    .wr_data(wr_data),
    .busy(bus_busy)
  );

  // command decode
  logic cmd_shutdown;
  logic cmd_cont;
  logic cmd_single;
  logic cmd_start;
  logic cmd_stop;
  logic period_end;
  mode_t mode_q;
  logic [7:0] cmd_q;
  result_t result_q;
  logic integrating_q;
  logic [PULSE_W-1:0] base_q;
  logic [TIMER_W-1:0] timer_q;

  assign cmd_shutdown = wr_valid && wr_data[CMD_SHUTDOWN_BIT];
  assign cmd_cont = cmd_is(wr_valid, wr_data, CMD_CONTINUOUS);
  assign cmd_single = cmd_is(wr_valid, wr_data, CMD_SINGLE);
  // start and stop only count in single mode
  assign cmd_start = cmd_is(wr_valid, wr_data, CMD_START) && (mode_q == MODE_SINGLE);
  assign cmd_stop = cmd_is(wr_valid, wr_data, CMD_STOP) && (mode_q == MODE_SINGLE);
  assign period_end = (mode_q == MODE_CONTINUOUS) && (timer_q == TIMER_LAST);

  // command byte store, every written byte kept for read-back
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cmd_q <= CMD_RESET;
    else if (wr_valid)
      cmd_q <= wr_data;
  end

  // mode; unlisted codes with top bit clear fall through untouched
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      mode_q <= MODE_SHUTDOWN;
    else if (cmd_shutdown)
      mode_q <= MODE_SHUTDOWN;
    else if (cmd_cont)
      mode_q <= MODE_CONTINUOUS;
    else if (cmd_single)
      mode_q <= MODE_SINGLE;
    else
      mode_q <= mode_q;
  end

  // continuous-mode integration timer; idle outside continuous mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      timer_q <= '0;
    else if (cmd_cont || (mode_q != MODE_CONTINUOUS) || period_end)
      timer_q <= '0;
    else
      timer_q <= timer_q + TIMER_W'(1);
  end

  // single-mode integration window
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      integrating_q <= 1'b0;
    else if (cmd_shutdown || cmd_cont || cmd_single)
      integrating_q <= 1'b0;
    else if (cmd_start)
      integrating_q <= 1'b1;
    else if (cmd_stop)
      integrating_q <= 1'b0;
  end

  // pulse count at the start of the current integration
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      base_q <= '0;
    else if (cmd_cont || cmd_start || period_end)
      base_q <= pulse_now;
  end

  // result register; reads never disturb it
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      result_q <= RESULT_RESET;
    else if (cmd_cont || cmd_single)
      result_q.valid <= 1'b0;
    else if (cmd_start)
      result_q <= RESULT_RESET;
    else if (cmd_stop && integrating_q)
      result_q <= make_result(pulse_now, base_q);
    else if (period_end)
      result_q <= make_result(pulse_now, base_q);
  end

  // shutdown answers with the command byte, active modes with the result word
  always_comb
  begin
    if (mode_q == MODE_SHUTDOWN)
      tx_word = {cmd_q, cmd_q};
    else
      tx_word = {result_q.valid, result_q.count};
  end

  assign mode = mode_q;
  assign command = cmd_q;
  assign result = result_q;
  assign integrating = integrating_q;

endmodule

// [src/light_sensor_pkg.sv]
// constants, types and state codes shared by the light sensor command and readout logic
// assumes a 50 MHz core clock and a free-running light-to-frequency pulse clock
package light_sensor_pkg;

  // bus address of the device, 7 bits
  localparam logic [6:0] DEV_ADDR = 7'h39;

  // command bytes
  localparam logic [7:0] CMD_CONTINUOUS = 8'h0c;
  localparam logic [7:0] CMD_SINGLE = 8'h04;
  localparam logic [7:0] CMD_START = 8'h08;
  localparam logic [7:0] CMD_STOP = 8'h30;
  localparam int CMD_SHUTDOWN_BIT = 7;

  // reset values
  localparam logic [7:0] CMD_RESET = 8'h80;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // result word layout
  localparam int RESULT_VALID_BIT = 15;
  localparam int COUNT_W = 15;
  localparam logic [14:0] COUNT_MAX = 15'h7fff;

  // pulse counter crossing from the sense domain, one bit wider than the count
  localparam int PULSE_W = 16;

  // continuous-mode integration period
  localparam int CORE_CLK_HZ = 50000000;
  localparam int INT_TIME_MS = 100;
  localparam int INT_CYCLES = INT_TIME_MS * (CORE_CLK_HZ / 1000);

  // bits per byte on the serial bus
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'b001,
    MODE_CONTINUOUS = 3'b010,
    MODE_SINGLE = 3'b100
  } mode_t;

  typedef enum logic [6:0] {
    BUS_IDLE = 7'b0000001,
    BUS_ADDR = 7'b0000010,
    BUS_ACK_ADDR = 7'b0000100,
    BUS_WRITE = 7'b0001000,
    BUS_ACK_WRITE = 7'b0010000,
    BUS_READ = 7'b0100000,
    BUS_ACK_READ = 7'b1000000
  } bus_state_t;

  typedef struct packed {
    logic valid;
    logic [14:0] count;
  } result_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_in_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } i2c_out_t;

endpackage

// [src/serial_byte_slave.sv]
// two-wire bus slave: address match, writes of any number of bytes, reads of up to two bytes
// assumes scl and sda arrive asynchronously; both pass two flip-flops here
`timescale 1ns/1ps
module serial_byte_slave
  import light_sensor_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus pins
  input wire light_sensor_pkg::i2c_in_t pins_in,
  output light_sensor_pkg::i2c_out_t pins_out,
  // user side
  input wire logic [15:0] tx_word,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic busy
);
  import light_sensor_pkg::*;

  logic [1:0] scl_meta_q;
  logic [1:0] sda_meta_q;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  bus_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [15:0] tx_q;
  logic byte_idx_q;
  logic master_ack_q;
  logic drive_low_q;

  // meta stage feeds the second stage and the edge and start/stop detection
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_meta_q <= {scl_meta_q[0], pins_in.scl};
      sda_meta_q <= {sda_meta_q[0], pins_in.sda};
      scl_q <= scl_meta_q[1];
      sda_q <= sda_meta_q[1];
    end
  end

  assign scl_rise = scl_meta_q[1] && !scl_q;
  assign scl_fall = !scl_meta_q[1] && scl_q;
  assign start_seen = scl_q && scl_meta_q[1] && sda_q && !sda_meta_q[1];
  assign stop_seen = scl_q && scl_meta_q[1] && !sda_q && sda_meta_q[1];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= BUS_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 16'h0000;
      byte_idx_q <= 1'b0;
      master_ack_q <= 1'b0;
      drive_low_q <= 1'b0;
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_valid <= 1'b0;
      if (start_seen)
      begin
        state_q <= BUS_ADDR;
        bit_cnt_q <= 4'h0;
        drive_low_q <= 1'b0;
      end
      else if (stop_seen)
      begin
        state_q <= BUS_IDLE;
        drive_low_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state_q)
          BUS_ADDR, BUS_WRITE:
          begin
            shift_q <= {shift_q[6:0], sda_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          BUS_READ:
            bit_cnt_q <= bit_cnt_q + 4'h1;
          BUS_ACK_READ:
            master_ack_q <= !sda_q;
          default:
            bit_cnt_q <= bit_cnt_q;
        endcase
      end
      else if (scl_fall)
      begin
        case (state_q)
          BUS_ADDR:
          begin
            if (bit_cnt_q == BITS_PER_BYTE)
            begin
              if (shift_q[7:1] == DEV_ADDR)
              begin
                state_q <= BUS_ACK_ADDR;
                drive_low_q <= 1'b1;
                // both bytes are frozen together so a word read never tears
                tx_q <= tx_word;
              end
              else
                state_q <= BUS_IDLE;
            end
          end
          BUS_ACK_ADDR:
          begin
            bit_cnt_q <= 4'h0;
            if (shift_q[0])
            begin
              state_q <= BUS_READ;
              byte_idx_q <= 1'b0;
              drive_low_q <= !tx_q[15];
            end
            else
            begin
              state_q <= BUS_WRITE;
              drive_low_q <= 1'b0;
            end
          end
          BUS_WRITE:
          begin
            if (bit_cnt_q == BITS_PER_BYTE)
            begin
              state_q <= BUS_ACK_WRITE;
              drive_low_q <= 1'b1;
              wr_valid <= 1'b1;
              wr_data <= shift_q;
            end
          end
          BUS_ACK_WRITE:
          begin
            state_q <= BUS_WRITE;
            bit_cnt_q <= 4'h0;
            drive_low_q <= 1'b0;
          end
          BUS_READ:
          begin
            if (bit_cnt_q == BITS_PER_BYTE)
            begin
              state_q <= BUS_ACK_READ;
              drive_low_q <= 1'b0;
            end
            else
            begin
              tx_q <= {tx_q[14:0], 1'b0};
              drive_low_q <= !tx_q[14];
            end
          end
          BUS_ACK_READ:
          begin
            bit_cnt_q <= 4'h0;
            // upper byte goes out first, then the lower byte
            if (master_ack_q && !byte_idx_q)
            begin
              state_q <= BUS_READ;
              byte_idx_q <= 1'b1;
              tx_q <= {tx_q[14:0], 1'b0};
              drive_low_q <= !tx_q[14];
            end
            else
              state_q <= BUS_IDLE;
          end
          default:
            state_q <= BUS_IDLE;
        endcase
      end
    end
  end

  // open drain: the pad only ever pulls low, so one driver sets both fields
  assign pins_out = '{sda_o: 1'b0, sda_oe: drive_low_q};
  assign busy = (state_q != BUS_IDLE);

endmodule

// [dv/sensor_monitor.sv]
// concurrent checks of the light sensor command readout block, core clock domain
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module sensor_monitor
  import light_sensor_pkg::*;
(
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sense_clk,
  // bus pins
  input wire light_sensor_pkg::i2c_in_t pins_in,
  input wire light_sensor_pkg::i2c_out_t pins_out,
  // status
  input wire light_sensor_pkg::mode_t mode,
  input wire logic [7:0] command,
  input wire light_sensor_pkg::result_t result,
  input wire logic integrating,
  input wire logic bus_busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_reset;
    $rose(rst_n) |-> mode == MODE_SHUTDOWN && command == CMD_RESET && !integrating
      && !result.valid;
  endproperty
  a_reset: assert property (p_reset) else $error("state after reset wrong");
  property p_shut;
    $changed(command) && command[CMD_SHUTDOWN_BIT] |-> mode == MODE_SHUTDOWN;
  endproperty
  a_shut: assert property (p_shut) else $error("top-bit command did not shut down");
  property p_cont_entry;
    $changed(command) && command == CMD_CONTINUOUS |-> mode == MODE_CONTINUOUS && !result.valid;
  endproperty
  a_cont_entry: assert property (p_cont_entry) else $error("continuous entry wrong");
  property p_single_entry;
    $changed(command) && command == CMD_SINGLE |-> mode == MODE_SINGLE && !result.valid;
  endproperty
  a_single_entry: assert property (p_single_entry) else $error("single entry wrong");
  property p_unlisted;
    $changed(command) && !command[7] && command != CMD_CONTINUOUS && command != CMD_SINGLE
      && command != CMD_START && command != CMD_STOP && mode != MODE_CONTINUOUS
      |-> $stable(mode) && $stable(result);
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted command had effect");
  property p_start;
    $rose(integrating) |-> mode == MODE_SINGLE && result == RESULT_RESET;
  endproperty
  a_start: assert property (p_start) else $error("start did not clear result");
  property p_stop;
    $fell(integrating) && command == CMD_STOP |-> result.valid && mode == MODE_SINGLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not set valid");
  property p_cont_idle;
    mode == MODE_CONTINUOUS |-> !integrating;
  endproperty
  a_cont_idle: assert property (p_cont_idle) else $error("integrating in continuous");
  property p_cont_hold;
    mode == MODE_CONTINUOUS && $past(mode) == MODE_CONTINUOUS && $past(result.valid)
      && $stable(command) |-> result.valid;
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("valid result lost");
  property p_single_hold;
    mode == MODE_SINGLE && $past(mode) == MODE_SINGLE && !integrating && !$past(integrating)
      && $stable(command) |-> $stable(result);
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("held result changed");

  c_integrate: cover property ($rose(integrating));
  c_cont_result: cover property (mode == MODE_CONTINUOUS && $rose(result.valid));
  c_shut_bus: cover property (mode == MODE_SHUTDOWN && $rose(bus_busy));
endmodule

// [dv/i2c_host_model.sv]
// bus master model: command writes, byte reads and word reads
// assumes an open-drain data line with a pull-up; the clock stands high between frames
`timescale 1ns/1ps
module i2c_host_model
  import light_sensor_pkg::*;
(
  // pacing clock
  input wire logic core_clk,
  // device pins
  input wire light_sensor_pkg::i2c_out_t pins_out,
  output light_sensor_pkg::i2c_in_t pins_in
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int half_cycles = 8;
  // pull-up: low whenever either party pulls
  assign pins_in = '{scl: scl_q, sda: sda_q & ~pins_out.sda_oe};

  task automatic half();
    repeat (half_cycles) @(negedge core_clk);
  endtask
  // data moves only while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    half();
    sda_q = b;
    half();
    scl_q = 1'b1;
    half();
    s = pins_in.sda;
    scl_q = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
                      output logic ack_n);
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(ack_bit, ack_n);
  endtask
  task automatic start();
    sda_q = 1'b0;
    half();
    scl_q = 1'b0;
  endtask
  task automatic stop();
    half();
    sda_q = 1'b0;
    half();
    scl_q = 1'b1;
    half();
    sda_q = 1'b1;
    half();
  endtask
  task automatic write_to(input logic [6:0] addr, input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic a0;
    logic a1;
    start();
    xfer({addr, 1'b0}, 1'b1, rx, a0);
    xfer(data, 1'b1, rx, a1);
    stop();
    ok = ~a0 & ~a1;
  endtask
  // the last byte wanted is refused, then the frame closes
  task automatic read(input int n, output logic [15:0] w, output logic ok);
    logic [7:0] b0;
    logic [7:0] b1;
    logic a0;
    logic a1;
    b1 = 8'h00;
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, b0, a0);
    xfer(8'hff, n == 1, b0, a1);
    if (n == 2)
      xfer(8'hff, 1'b1, b1, a1);
    stop();
    w = (n == 1) ? {8'h00, b0} : {b0, b1};
    ok = ~a0;
  endtask
endmodule

// [dv/light_sensor_command_readout_test.sv]
// self-checking bench of the light sensor command readout block
// assumes the host model drives the bus and the sense clock runs free
`timescale 1ns/1ps
`define CHK(g, e) check(16'(g), 16'(e))
module light_sensor_command_readout_test;
  import light_sensor_pkg::*;
  localparam int PERIOD = 2000;
  logic core_clk = 1'b0;
  logic sense_clk = 1'b0;
  logic rst_n = 1'b0;
  i2c_in_t pins_in;
  i2c_out_t pins_out;
  mode_t mode;
  logic [7:0] command;
  result_t result;
  logic integrating;
  logic bus_busy;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  realtime t_open;
  realtime t_close;
  logic ok;
  logic [15:0] w;
  logic [15:0] w2;
  logic [7:0] c;

  always #10 core_clk = ~core_clk;
  always #7.5 sense_clk = ~sense_clk;
  always @(posedge integrating) t_open = $realtime;
  always @(negedge integrating) t_close = $realtime;

  light_sensor_command_readout #(.INT_PERIOD_CYCLES(PERIOD)) uut (.core_clk, .rst_n,
    .sense_clk, .pins_in, .pins_out, .mode, .command, .result, .integrating, .bus_busy);
  i2c_host_model host (.core_clk, .pins_out, .pins_in);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // count expected from the open time, allowing for the crossing latency
  function automatic logic near(input logic [14:0] got, input realtime dt);
    int e;
    e = int'(dt / 15.0);
    return (int'(got) >= e - 8) && (int'(got) <= e + 8);
  endfunction
  task automatic wr(input logic [7:0] v);
    host.write_to(DEV_ADDR, v, ok);
    `CHK(ok, 1'b1);
    repeat (2) @(negedge core_clk);
    `CHK(bus_busy, 1'b0);
  endtask
  task automatic wait_change();
    result_t r0;
    r0 = result;
    for (int i = 0; i < 3 * PERIOD && result === r0; i++)
      @(negedge core_clk);
  endtask
  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'h2885442a));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(mode, MODE_SHUTDOWN);
    `CHK(command, CMD_RESET);
    for (int i = 0; i < 3; i++)
    begin
      c = 8'h80 | 8'($urandom);
      wr(c);
      `CHK(mode, MODE_SHUTDOWN);
      host.read(1, w, ok);
      `CHK(w[7:0], c);
    end
    host.write_to(7'h29, CMD_CONTINUOUS, ok);
    `CHK(ok, 1'b0);
    `CHK(mode, MODE_SHUTDOWN);
    done("shutdown");
    wr(CMD_CONTINUOUS);
    `CHK(mode, MODE_CONTINUOUS);
    host.read(2, w, ok);
    `CHK(w[15], 1'b0);
    wr(CMD_START);
    wr(CMD_STOP);
    `CHK(mode, MODE_CONTINUOUS);
    `CHK(integrating, 1'b0);
    wait_change();
    // two refreshes may carry the same count; a fixed wait lands just after the next one
    repeat (PERIOD) @(negedge core_clk);
    host.read(2, w, ok);
    host.read(2, w2, ok);
    `CHK(w2, w);
    `CHK(result, w);
    `CHK(w[14:0], result.count);
    `CHK(w[15], 1'b1);
    `CHK(near(w[14:0], PERIOD * 20.0), 1'b1);
    done("continuous");
    wr(CMD_SINGLE);
    `CHK(mode, MODE_SINGLE);
    `CHK(result.valid, 1'b0);
    wr(CMD_STOP);
    `CHK(result.valid, 1'b0);
    wr(CMD_START);
    `CHK(integrating, 1'b1);
    host.read(2, w, ok);
    `CHK(w, 16'h0000);
    repeat (500 + $urandom_range(1000)) @(negedge core_clk);
    wr(CMD_STOP);
    `CHK(integrating, 1'b0);
    host.half_cycles = 20;
    host.read(2, w, ok);
    `CHK(w[15], 1'b1);
    `CHK(near(w[14:0], t_close - t_open), 1'b1);
    repeat (1000) @(negedge core_clk);
    host.read(2, w2, ok);
    host.half_cycles = 8;
    `CHK(w2, w);
    for (int i = 0; i < 3; i++)
    begin
      c = 8'h40 | 8'($urandom_range(63));
      wr(c);
      `CHK(mode, MODE_SINGLE);
      `CHK(result, w);
      `CHK(command, c);
    end
    done("single");
    c = 8'h80 | 8'($urandom);
    wr(c);
    `CHK(mode, MODE_SHUTDOWN);
    host.read(1, w2, ok);
    `CHK(w2[7:0], c);
    rst_n = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    `CHK(command, CMD_RESET);
    `CHK(mode, MODE_SHUTDOWN);
    done("shutdown and reset");
    report_and_stop();
  end
endmodule

bind light_sensor_command_readout sensor_monitor mon (.core_clk, .rst_n, .sense_clk,
  .pins_in, .pins_out, .mode, .command, .result, .integrating, .bus_busy);
